// ===== design/ispc_cfg.svh
// Register offsets, bit positions and timing constants for the ISP control block
`ifndef ISPC_CFG_SVH
`define ISPC_CFG_SVH
`define ISPC_PROG_CONTROL_OFF 8'h9f
`define ISPC_PC_ADDR 12'h27c
`define ISPC_IDLE_ADDR 12'h280
`define ISPC_TIMER_ADDR 12'h284
`define ISPC_STATUS_ADDR 12'h288
`define ISPC_BIT_RESET 7
`define ISPC_BIT_EXEC_STAT 5
`define ISPC_BIT_FETCH_SEL 1
`define ISPC_BIT_PROG_EN 0
`define ISPC_BIT_REQ 0
`define ISPC_WMASK 8'h83
`define ISPC_SOFT_RESET_VAL 8'h83
`define ISPC_RESET_PULSE_CYC 4'h4
`define ISPC_RESP_OKAY 2'h0
`define ISPC_RESP_SLVERR 2'h2
`endif

// ===== design/ispc_pkg.sv
// Types for the ISP control block
package ispc_pkg;
	typedef enum logic [3:0] {
		ISPC_RUN = 4'h1,
		ISPC_IDLE = 4'h2,
		ISPC_FLASH_OP = 4'h4,
		ISPC_RESET = 4'h8
	} ispc_state_e;
endpackage

// ===== design/ispc_top.sv
// ISP control register, software reset sequencer and idle/flash-op steering
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "ispc_cfg.svh"
module ispc_top
	import ispc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Device side pins
	input wire logic hw_reboot_pin,
	input wire logic timer_expire_pin,
	output logic device_reset,
	output logic loader_fetch,
	output logic prog_mode,
	output logic cpu_idle,
	output logic flash_op_start
);

	function automatic logic [31:0] ispc_byte(input logic [7:0] v);
		ispc_byte = {24'h000000, v};
	endfunction

	// Pin synchronisers
	logic reboot_s1, reboot_s2, tmo_s1, tmo_s2;
	logic next_reboot_s1, next_reboot_s2, next_tmo_s1, next_tmo_s2;

	// Register state
	logic reset_bit, fetch_sel, prog_en, exec_stat, timer_run;
	logic next_reset_bit, next_fetch_sel, next_prog_en, next_exec_stat, next_timer_run;
	ispc_state_e state, next_state;
	logic [3:0] rst_cnt, next_rst_cnt;
	logic device_reset_q, loader_fetch_q, prog_mode_q, cpu_idle_q, flash_op_q;
	logic next_device_reset, next_loader_fetch, next_prog_mode, next_cpu_idle, next_flash_op;

	// Bus state
	logic [11:0] aw_addr, next_aw_addr;
	logic aw_have, w_have, next_aw_have, next_w_have;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic awready_q, wready_q, arready_q;
	logic next_awready, next_wready, next_arready;

	logic do_write;
	logic [7:0] wbyte;

	// Pins are asynchronous to sys_clk; logic reads only the second stage
	always_comb begin
		next_reboot_s1 = hw_reboot_pin;
		next_reboot_s2 = reboot_s1;
		next_tmo_s1 = timer_expire_pin;
		next_tmo_s2 = tmo_s1;
	end

	// Bus channel capture: address and data taken in either order
	always_comb begin
		next_aw_addr = aw_addr;
		next_aw_have = aw_have;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_w_have = w_have;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		do_write = 1'b0;
		wbyte = w_data[7:0];
		if (s_axi_awvalid && awready_q) begin
			next_aw_addr = s_axi_awaddr;
			next_aw_have = 1'b1;
		end
		if (s_axi_wvalid && wready_q) begin
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_w_have = 1'b1;
		end
		if (aw_have && w_have && !bvalid) begin
			do_write = 1'b1;
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (aw_addr[11:2] == 10'(`ISPC_PC_ADDR >> 2)) ? `ISPC_RESP_OKAY
				: (aw_addr[11:2] == 10'(`ISPC_IDLE_ADDR >> 2)) ? `ISPC_RESP_OKAY
				: (aw_addr[11:2] == 10'(`ISPC_TIMER_ADDR >> 2)) ? `ISPC_RESP_OKAY
				: `ISPC_RESP_SLVERR;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			next_rvalid = 1'b1;
			next_rresp = `ISPC_RESP_OKAY;
			unique case (s_axi_araddr[11:2])
				10'(`ISPC_PC_ADDR >> 2): begin
					// Bit 7 reads as reboot mode, not the written trigger
					next_rdata = ispc_byte({reboot_s2, 1'b0, exec_stat, 3'h0, fetch_sel, prog_en});
				end
				10'(`ISPC_STATUS_ADDR >> 2): begin
					next_rdata = ispc_byte({4'h0, state});
				end
				10'(`ISPC_IDLE_ADDR >> 2), 10'(`ISPC_TIMER_ADDR >> 2): begin
					next_rdata = ispc_byte({6'h00, timer_run, cpu_idle_q});
				end
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `ISPC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		// Readies are registered so every bus output comes from a flop;
		// the capture tests above use the same flops, so handshake and capture agree
		next_awready = !next_aw_have && !next_bvalid;
		next_wready = !next_w_have && !next_bvalid;
		next_arready = !next_rvalid;
	end

	// Control register, idle/flash-op steering and reset sequencer
	always_comb begin
		next_reset_bit = reset_bit;
		next_fetch_sel = fetch_sel;
		next_prog_en = prog_en;
		next_exec_stat = exec_stat;
		next_timer_run = timer_run;
		next_state = state;
		next_rst_cnt = rst_cnt;
		next_flash_op = 1'b0;
		if (do_write && w_strb[0] && aw_addr[11:2] == 10'(`ISPC_PC_ADDR >> 2)) begin
			next_reset_bit = wbyte[`ISPC_BIT_RESET];
			next_fetch_sel = wbyte[`ISPC_BIT_FETCH_SEL];
			next_prog_en = wbyte[`ISPC_BIT_PROG_EN];
		end
		unique case (state)
			ISPC_RUN: begin
				if (do_write && w_strb[0] && aw_addr[11:2] == 10'(`ISPC_IDLE_ADDR >> 2)
					&& wbyte[`ISPC_BIT_REQ]) begin
					// Idle request becomes a flash op while in programming mode
					if (prog_en) begin
						next_state = ISPC_FLASH_OP;
						next_flash_op = 1'b1;
					end else begin
						next_state = ISPC_IDLE;
					end
				end else if (reset_bit && !(fetch_sel && prog_en)) begin
					// Plain trigger resets at once; 0x83 waits for the timer
					next_rst_cnt = `ISPC_RESET_PULSE_CYC;
					next_state = ISPC_RESET;
				end
			end
			ISPC_IDLE: begin
				if (timer_run && tmo_s2) begin
					next_rst_cnt = `ISPC_RESET_PULSE_CYC;
					next_state = reset_bit ? ISPC_RESET : ISPC_RUN;
					next_timer_run = 1'b0;
				end
			end
			ISPC_FLASH_OP: begin
				// One-cycle launch, then idle waits only for the timer expiry
				next_state = ISPC_IDLE;
			end
			ISPC_RESET: begin
				next_rst_cnt = rst_cnt - 4'h1;
				if (rst_cnt == 4'h1) begin
					// Back to initial state, trigger self-clears
					next_state = ISPC_RUN;
					next_reset_bit = 1'b0;
					next_prog_en = 1'b0;
					next_fetch_sel = 1'b0;
					next_timer_run = 1'b0;
					next_exec_stat = 1'b0;
				end
			end
		endcase
		// Placed after the sequencer so a timer start landing with the expiry wins
		if (do_write && w_strb[0] && aw_addr[11:2] == 10'(`ISPC_TIMER_ADDR >> 2)) begin
			next_timer_run = wbyte[`ISPC_BIT_REQ];
		end
		if (state != ISPC_RESET) begin
			next_exec_stat = fetch_sel;
		end
		next_device_reset = (next_state == ISPC_RESET);
		next_loader_fetch = next_fetch_sel;
		next_prog_mode = next_prog_en;
		next_cpu_idle = (next_state == ISPC_IDLE) || (next_state == ISPC_FLASH_OP);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reboot_s1 <= 1'b0;
			reboot_s2 <= 1'b0;
			tmo_s1 <= 1'b0;
			tmo_s2 <= 1'b0;
			reset_bit <= 1'b0;
			fetch_sel <= 1'b0;
			prog_en <= 1'b0;
			exec_stat <= 1'b0;
			timer_run <= 1'b0;
			state <= ISPC_RUN;
			rst_cnt <= 4'h0;
			device_reset_q <= 1'b0;
			loader_fetch_q <= 1'b0;
			prog_mode_q <= 1'b0;
			cpu_idle_q <= 1'b0;
			flash_op_q <= 1'b0;
			aw_addr <= 12'h000;
			aw_have <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			w_have <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= 32'h00000000;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end else begin
			reboot_s1 <= next_reboot_s1;
			reboot_s2 <= next_reboot_s2;
			tmo_s1 <= next_tmo_s1;
			tmo_s2 <= next_tmo_s2;
			reset_bit <= next_reset_bit;
			fetch_sel <= next_fetch_sel;
			prog_en <= next_prog_en;
			exec_stat <= next_exec_stat;
			timer_run <= next_timer_run;
			state <= next_state;
			rst_cnt <= next_rst_cnt;
			device_reset_q <= next_device_reset;
			loader_fetch_q <= next_loader_fetch;
			prog_mode_q <= next_prog_mode;
			cpu_idle_q <= next_cpu_idle;
			flash_op_q <= next_flash_op;
			aw_addr <= next_aw_addr;
			aw_have <= next_aw_have;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			w_have <= next_w_have;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			awready_q <= next_awready;
			wready_q <= next_wready;
			arready_q <= next_arready;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_arready = arready_q;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign device_reset = device_reset_q;
	assign loader_fetch = loader_fetch_q;
	assign prog_mode = prog_mode_q;
	assign cpu_idle = cpu_idle_q;
	assign flash_op_start = flash_op_q;

endmodule

// ===== test/ispc_top_assertions.sv
// Checker for the ISP control block outputs
`timescale 1ns/1ns
module ispc_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Watched outputs, plus the s_axi_rready input
	input wire logic device_reset,
	input wire logic loader_fetch,
	input wire logic prog_mode,
	input wire logic cpu_idle,
	input wire logic flash_op_start,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	rst_pulse_a: assert property ($rose(device_reset) |-> device_reset[*4] ##1 !device_reset)
		else $error("reset pulse length wrong");
	rst_done_a: assert property ($fell(device_reset) |-> !loader_fetch && !prog_mode)
		else $error("state not cleared after reset");
	op_pulse_a: assert property (flash_op_start |=> !flash_op_start)
		else $error("flash op start too long");
	op_mode_a: assert property (flash_op_start |-> prog_mode)
		else $error("flash op outside prog mode");
	op_idle_a: assert property (flash_op_start |-> ##[0:2] cpu_idle)
		else $error("flash op without idle");
	true_idle_a: assert property ($rose(cpu_idle) && !prog_mode |-> !flash_op_start)
		else $error("flash op on plain idle");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule
bind ispc_top ispc_chk ispc_chk_i (.*);

// ===== test/tb.sv
// Self-checking bench for the ISP control block
`timescale 1ns/1ns
module tb;
	logic sys_clk = 0, rst_n = 0, hw_reboot_pin = 0, timer_expire_pin = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, device_reset, loader_fetch, prog_mode, cpu_idle, flash_op_start;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d, lf = 32'he284d277;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	wire logic [1:0] mon = {cpu_idle, device_reset};
	int bad_count = 0, total_checks = 0, cyc = 0, ops = 0;
	// Reference model of the control register bits 1:0
	int m_ctl = 0;
	ispc_top ispc_top_i (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.hw_reboot_pin(hw_reboot_pin),
		.timer_expire_pin(timer_expire_pin),
		.device_reset(device_reset),
		.loader_fetch(loader_fetch),
		.prog_mode(prog_mode),
		.cpu_idle(cpu_idle),
		.flash_op_start(flash_op_start)
	);
	function automatic logic [31:0] exp_ctl(input int c, input logic hw);
		return {24'h0, hw, 1'h0, c[1], 3'h0, c[1:0]};
	endfunction
	initial forever #25 sys_clk = ~sys_clk;
	task close_out;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Sampled off the edge so design updates have landed
	always @(negedge sys_clk) begin
		cyc++;
		if (flash_op_start === 1'h1)
			ops++;
		if (cyc == 5000) begin
			bad_count++;
			close_out;
		end
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input logic [39:0] s, e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic ao, wo, dn;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge sys_clk);
			ao = s_axi_awready;
			wo = s_axi_wready;
			dn = s_axi_bvalid;
			wr_r = s_axi_bresp;
			@(posedge sys_clk);
			if (ao)
				s_axi_awvalid <= 1'h0;
			if (wo)
				s_axi_wvalid <= 1'h0;
			if (dn)
				s_axi_bready <= 1'h0;
		end while (!dn);
	endtask
	// Ready raised only after valid is seen, so a stall gets exercised
	task rd(input logic [11:0] a);
		logic ao, ro, dn;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(negedge sys_clk);
			ao = s_axi_arready;
			ro = s_axi_rvalid;
			dn = ro && s_axi_rready;
			rd_d = s_axi_rdata;
			rd_r = s_axi_rresp;
			@(posedge sys_clk);
			if (ao)
				s_axi_arvalid <= 1'h0;
			s_axi_rready <= ro && !dn;
		end while (!dn);
	endtask
	task wt(input int k, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (mon[k] !== v && n < 99);
		chk(mon[k], v);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			lf = nx(lf);
			@(posedge sys_clk) hw_reboot_pin <= lf[4];
			wr(12'h27c, lf & 32'hffffff7f);
			m_ctl = lf & 32'h3;
			repeat (3) @(posedge sys_clk);
			rd(12'h27c);
			chk(rd_d, exp_ctl(m_ctl, lf[4]));
			chk({wr_r, loader_fetch, prog_mode}, {2'h0, m_ctl[1:0]});
		end
		@(posedge sys_clk) s_axi_wstrb <= 4'he;
		wr(12'h27c, ~lf & 32'h7f);
		@(posedge sys_clk) s_axi_wstrb <= 4'hf;
		chk({wr_r, loader_fetch, prog_mode}, {2'h0, m_ctl[1:0]});
		wr(12'h300, 32'h3);
		chk({wr_r, loader_fetch, prog_mode}, {2'h2, m_ctl[1:0]});
		rd(12'h300);
		chk({rd_r, rd_d}, {2'h2, 32'h0});
		@(posedge sys_clk) hw_reboot_pin <= 1'h0;
		wr(12'h27c, 32'h82);
		m_ctl = 0;
		wt(0, 1'h1);
		wt(0, 1'h0);
		rd(12'h27c);
		chk(rd_d, exp_ctl(m_ctl, 1'h0));
		wr(12'h284, 32'h1);
		wr(12'h280, 32'h1);
		wt(1, 1'h1);
		@(posedge sys_clk) timer_expire_pin <= 1'h1;
		wt(1, 1'h0);
		chk({ops, device_reset}, 33'h0);
		@(posedge sys_clk) timer_expire_pin <= 1'h0;
		wr(12'h27c, 32'h83);
		m_ctl = 3;
		wr(12'h284, 32'h1);
		wr(12'h280, 32'h1);
		wt(1, 1'h1);
		repeat (2) @(negedge sys_clk);
		chk({ops, loader_fetch}, {32'h1, m_ctl[1]});
		rd(12'h288);
		chk(rd_d, 32'(ispc_pkg::ISPC_IDLE));
		rd(12'h280);
		chk(rd_d, 32'h3);
		@(posedge sys_clk) timer_expire_pin <= 1'h1;
		wt(0, 1'h1);
		@(posedge sys_clk) timer_expire_pin <= 1'h0;
		wt(0, 1'h0);
		chk({loader_fetch, prog_mode, cpu_idle}, 3'h0);
		close_out;
	end
endmodule
